// ==== core/beat_fifo.sv ====
// Parameterised valid/ready FIFO holding pending self-timed writes
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_state_t;

    fifo_state_t st_r;
    fifo_state_t st_nxt;
    logic [AW:0] fill;

    assign fill = st_r.wp - st_r.rp;
    assign in_ready = (fill != DEPTH_CNT);
    assign out_valid = (fill != '0);
    assign out_data = st_r.slot[st_r.rp[AW-1:0]];

    always_comb
    begin
        st_nxt = st_r;
        if (in_valid && in_ready)
        begin
            st_nxt.slot[st_r.wp[AW-1:0]] = in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (out_valid && out_ready)
        begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_r.wp <= '0;
            st_r.rp <= '0;
            st_r.slot <= st_nxt.slot;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    a_fifo_no_overrun: assert property (@(posedge ref_clk) disable iff (reset)
        !in_ready |=> (st_r.wp == $past(st_r.wp)) || $past(in_valid) == 1'b0)
        else $error("fifo accepted a beat while full");

endmodule
`default_nettype wire

// ==== core/burst_sram_pkg.sv ====
// Shared constants and carrier types for the synchronous burst word store
package burst_sram_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 9;
    localparam int LOW_W = 2;
    localparam int HIGH_W = ADDR_W - LOW_W;
    localparam int WORDS = 32768;
    localparam int FIFO_DEPTH = 16;
    localparam logic [LOW_W-1:0] CNT_STEP = 2'h1;
    localparam int BURST_LEN = 4;

    // Gray order along desel -> read -> write
    typedef enum logic [1:0] {
        OP_DESEL = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h3
    } op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } write_beat_t;

    localparam int BEAT_W = $bits(write_beat_t);

    typedef struct packed {
        logic [HIGH_W-1:0] base_hi;
        logic [LOW_W-1:0] cnt;
        logic sel;
        op_t op;
        logic wr_prev;
        logic [DATA_W-1:0] rdata;
    } sram_state_t;

    localparam sram_state_t STATE_RESET = '{
        base_hi: '0,
        cnt: '0,
        sel: 1'b0,
        op: OP_DESEL,
        wr_prev: 1'b0,
        rdata: '0
    };

endpackage

// ==== core/sync_burst_sram_32kx9.sv ====
// Synchronous burst word store: input capture, burst counter, array and pin drive
//
// Behaviour
// - Store 32768 nine-bit words, fifteen-bit index
// - Capture address, data, controls on rising edge
// - Either transfer start begins a burst
// - Burst counter loads the two low bits
// - Counter steps alike for reads and writes
// - After full count, wrap to base address
// - Processor start or strobe high means read
// - Write start needs controller start and selects
// - Advance low steps address; strobe picks direction
// - Advance high holds address as wait state
// - Any start abandons burst, loads new base
// - Selects sampled on starts, latched until next
// - Deselect decoded from selects at start edge
// - Output enable gates data drivers asynchronously
// - Registered write strobe forces drivers off
// - Writes complete self-timed from strobe edge
// - Advanced address updates on advance edge
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_32kx9 #(
    parameter int FIFO_DEPTH = burst_sram_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [burst_sram_pkg::ADDR_W-1:0] word_index,
    input wire logic [burst_sram_pkg::DATA_W-1:0] data_pins_in,
    output logic [burst_sram_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe,
    input wire logic store_strobe_n,
    input wire logic drive_on_n,
    input wire logic select_active_hi,
    input wire logic select_active_lo_n,
    input wire logic proc_transfer_start_n,
    input wire logic ctrl_transfer_start_n,
    input wire logic burst_advance_n,
    input wire logic array_hold,
    output logic write_ready
);

    burst_sram_pkg::sram_state_t st_r;
    burst_sram_pkg::sram_state_t st_nxt;

    // Array itself is kept outside the state record; it has no reset
    logic [burst_sram_pkg::DATA_W-1:0] mem [burst_sram_pkg::WORDS];

    logic start;
    logic proc_start;
    logic advance;
    logic [burst_sram_pkg::ADDR_W-1:0] acc_addr;
    logic push;
    burst_sram_pkg::write_beat_t push_beat;
    logic drain_valid;
    logic drain_fire;
    burst_sram_pkg::write_beat_t drain_beat;
    logic [burst_sram_pkg::BEAT_W-1:0] drain_bits;

    assign start = !proc_transfer_start_n || !ctrl_transfer_start_n;
    assign proc_start = !proc_transfer_start_n;
    assign advance = !start && !burst_advance_n;
    assign drain_beat = burst_sram_pkg::write_beat_t'(drain_bits);
    assign drain_fire = drain_valid && !array_hold;

    always_comb
    begin
        st_nxt = st_r;
        if (start)
        begin
            // New base abandons whatever burst was running
            st_nxt.base_hi = word_index[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::LOW_W];
            st_nxt.cnt = word_index[burst_sram_pkg::LOW_W-1:0];
            st_nxt.sel = select_active_hi && !select_active_lo_n;
        end
        else if (advance)
        begin
            // Same step for read and write; four steps return to the base
            st_nxt.cnt = st_r.cnt + burst_sram_pkg::CNT_STEP;
        end
        acc_addr = {st_nxt.base_hi, st_nxt.cnt};
        if (!st_nxt.sel)
        begin
            st_nxt.op = burst_sram_pkg::OP_DESEL;
        end
        else if (proc_start || store_strobe_n)
        begin
            st_nxt.op = burst_sram_pkg::OP_READ;
        end
        else
        begin
            st_nxt.op = burst_sram_pkg::OP_WRITE;
        end
        st_nxt.wr_prev = !store_strobe_n;
        // Forward a beat committed on this same edge; beats still waiting in the queue are not forwarded
        if (drain_fire && (drain_beat.addr == acc_addr))
        begin
            st_nxt.rdata = drain_beat.data;
        end
        else
        begin
            st_nxt.rdata = mem[acc_addr];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_r <= burst_sram_pkg::STATE_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Writes are queued and retire on their own, no further pin activity needed
    assign push = (st_nxt.op == burst_sram_pkg::OP_WRITE) && !reset;
    assign push_beat = '{addr: acc_addr, data: data_pins_in};

    beat_fifo #(
        .WIDTH(burst_sram_pkg::BEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_write_queue (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(push),
        .in_ready(write_ready),
        .in_data(push_beat),
        .out_valid(drain_valid),
        .out_ready(!array_hold),
        .out_data(drain_bits)
    );

    always_ff @(posedge ref_clk)
    begin
        if (drain_fire)
        begin
            mem[drain_beat.addr] <= drain_beat.data;
        end
    end

    // Enable path is combinational so the output follows drive_on_n at once
    assign data_pins_out = st_r.rdata;
    assign data_pins_oe = (st_r.op == burst_sram_pkg::OP_READ) && !drive_on_n
        && !st_r.wr_prev;

    a_start_loads_base: assert property (@(posedge ref_clk) disable iff (reset)
        start |=> {st_r.base_hi, st_r.cnt} == $past(word_index))
        else $error("start did not load the base address");

    a_advance_steps: assert property (@(posedge ref_clk) disable iff (reset)
        advance |=> (st_r.cnt == $past(st_r.cnt) + burst_sram_pkg::CNT_STEP)
            && $stable(st_r.base_hi))
        else $error("advance did not step the counter by one");

    a_suspend_holds: assert property (@(posedge ref_clk) disable iff (reset)
        (!start && burst_advance_n) |=> $stable(st_r.cnt) && $stable(st_r.base_hi))
        else $error("wait state moved the burst address");

    a_burst_wraps: assert property (@(posedge ref_clk) disable iff (reset)
        advance [*4] |=> st_r.cnt == $past(st_r.cnt, 4))
        else $error("four advances did not wrap to the base");

    a_proc_reads: assert property (@(posedge ref_clk) disable iff (reset)
        proc_start |=> st_r.op != burst_sram_pkg::OP_WRITE)
        else $error("processor start produced a write");

    a_write_begin: assert property (@(posedge ref_clk) disable iff (reset)
        (!ctrl_transfer_start_n && !proc_start && select_active_hi && !select_active_lo_n
            && !store_strobe_n) |-> push ##1 (st_r.op == burst_sram_pkg::OP_WRITE))
        else $error("controller write start was not taken");

    a_selects_latched: assert property (@(posedge ref_clk) disable iff (reset)
        !start |=> $stable(st_r.sel))
        else $error("selects changed without a transfer start");

    a_desel_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        !st_r.sel |-> !data_pins_oe && (start || !push))
        else $error("deselected device drove pins or wrote");

    a_strobe_blocks_oe: assert property (@(posedge ref_clk) disable iff (reset)
        !store_strobe_n |=> !data_pins_oe)
        else $error("drivers on after registered write strobe");

    a_read_drives: assert property (@(posedge ref_clk) disable iff (reset)
        (st_r.op == burst_sram_pkg::OP_READ && !st_r.wr_prev && !drive_on_n) |-> data_pins_oe)
        else $error("read with enable low left drivers off");

    // Start, select and counter loading
    a_ctrl_start_loads: assert property (@(posedge ref_clk) disable iff (reset)
        !ctrl_transfer_start_n |=> {st_r.base_hi, st_r.cnt} == $past(word_index))
        else $error("controller start did not load the base");

    a_proc_start_loads: assert property (@(posedge ref_clk) disable iff (reset)
        !proc_transfer_start_n |=> {st_r.base_hi, st_r.cnt} == $past(word_index))
        else $error("processor start did not load the base");

    a_start_beats_adv: assert property (@(posedge ref_clk) disable iff (reset)
        (start && !burst_advance_n) |=> st_r.cnt == $past(word_index[burst_sram_pkg::LOW_W-1:0]))
        else $error("advance overrode a transfer start");

    a_select_decode: assert property (@(posedge ref_clk) disable iff (reset)
        start |=> st_r.sel == $past(select_active_hi && !select_active_lo_n))
        else $error("selects not registered on start");

    a_proc_desel: assert property (@(posedge ref_clk) disable iff (reset)
        (proc_start && !select_active_hi) |=> !st_r.sel)
        else $error("processor start with low select stayed selected");

    a_ctrl_desel: assert property (@(posedge ref_clk) disable iff (reset)
        (!ctrl_transfer_start_n && !proc_start && select_active_lo_n) |=> !st_r.sel)
        else $error("controller start with high select stayed selected");

    a_select_hold: assert property (@(posedge ref_clk) disable iff (reset)
        (!start && $changed(select_active_hi)) |=> $stable(st_r.sel))
        else $error("select pin change leaked into latched select");

    a_desel_keeps_op: assert property (@(posedge ref_clk) disable iff (reset)
        (!start && !st_r.sel) |=> st_r.op == burst_sram_pkg::OP_DESEL)
        else $error("deselected device left the deselect state");

    // Direction and queueing
    a_desel_no_push: assert property (@(posedge ref_clk) disable iff (reset)
        (!st_r.sel && !start) |-> !push)
        else $error("deselected device queued a write");

    a_desel_no_drive: assert property (@(posedge ref_clk) disable iff (reset)
        (st_r.op == burst_sram_pkg::OP_DESEL) |-> !data_pins_oe)
        else $error("deselected device drove the pins");

    a_write_no_drive: assert property (@(posedge ref_clk) disable iff (reset)
        (st_r.op == burst_sram_pkg::OP_WRITE) |-> !data_pins_oe)
        else $error("write cycle drove the pins");

    a_oe_off_high: assert property (@(posedge ref_clk) disable iff (reset)
        drive_on_n |-> !data_pins_oe)
        else $error("pins driven with enable high");

    a_proc_sel_read: assert property (@(posedge ref_clk) disable iff (reset)
        (proc_start && select_active_hi && !select_active_lo_n) |=> st_r.op == burst_sram_pkg::OP_READ)
        else $error("selected processor start was not a read");

    a_ctrl_high_read: assert property (@(posedge ref_clk) disable iff (reset)
        (!ctrl_transfer_start_n && !proc_start && select_active_hi && !select_active_lo_n
            && store_strobe_n) |=> st_r.op == burst_sram_pkg::OP_READ)
        else $error("controller start with strobe high was not a read");

    a_adv_write_push: assert property (@(posedge ref_clk) disable iff (reset)
        (advance && st_r.sel && !store_strobe_n) |-> push)
        else $error("advancing write was not queued");

    a_adv_read_op: assert property (@(posedge ref_clk) disable iff (reset)
        (advance && st_r.sel && store_strobe_n) |=> st_r.op == burst_sram_pkg::OP_READ)
        else $error("advancing read was not a read");

    a_wait_write: assert property (@(posedge ref_clk) disable iff (reset)
        (!start && burst_advance_n && st_r.sel && !store_strobe_n) |-> push)
        else $error("write in a wait state was not queued");

    a_wait_read: assert property (@(posedge ref_clk) disable iff (reset)
        (!start && burst_advance_n && st_r.sel && store_strobe_n) |=> st_r.op == burst_sram_pkg::OP_READ)
        else $error("read in a wait state was not a read");

    a_wr_prev_track: assert property (@(posedge ref_clk) disable iff (reset)
        !store_strobe_n |=> st_r.wr_prev)
        else $error("write strobe was not registered");

    a_wr_prev_blocks: assert property (@(posedge ref_clk) disable iff (reset)
        st_r.wr_prev |-> !data_pins_oe)
        else $error("pins driven after a registered strobe");

    // Self-timed write queue
    a_write_retires: assert property (@(posedge ref_clk) disable iff (reset)
        (push && write_ready && !drain_valid) |=> drain_valid)
        else $error("accepted write did not reach the commit side");

    a_idle_no_push: assert property (@(posedge ref_clk) disable iff (reset)
        store_strobe_n |-> !push)
        else $error("write queued with strobe high");

    a_hold_no_commit: assert property (@(posedge ref_clk) disable iff (reset)
        array_hold |-> !drain_fire)
        else $error("array committed while held");

    // Counter arithmetic
    a_counter_wrap: assert property (@(posedge ref_clk) disable iff (reset)
        (advance && st_r.cnt == '1) |=> st_r.cnt == '0)
        else $error("counter did not wrap modulo four");

    a_write_step: assert property (@(posedge ref_clk) disable iff (reset)
        (advance && !store_strobe_n) |=> st_r.cnt == $past(st_r.cnt) + burst_sram_pkg::CNT_STEP)
        else $error("write burst stepped differently");

    a_adv_edge_addr: assert property (@(posedge ref_clk) disable iff (reset)
        advance |-> acc_addr[burst_sram_pkg::LOW_W-1:0] == st_r.cnt + burst_sram_pkg::CNT_STEP)
        else $error("advance edge did not use the stepped address");

endmodule
`default_nettype wire

// ==== dv/ctrl_side_model.sv ====
// Far-side controller model: resolves the shared data pins
`timescale 1ns/1ps
`default_nettype none
module ctrl_side_model #(
    parameter int W = burst_sram_pkg::DATA_W
) (
    input wire logic ref_clk,
    input wire logic [W-1:0] sram_out,
    input wire logic sram_oe,
    input wire logic [W-1:0] host_data,
    input wire logic host_drive,
    output logic [W-1:0] pins
);
    logic [W-1:0] last_r;
    initial last_r = '0;
    // Released pins show a changing pattern, never a stale copy of the last value
    always_comb
    begin
        if (sram_oe)
            pins = sram_out;
        else if (host_drive)
            pins = host_data;
        else
            pins = ~last_r;
    end
    always @(posedge ref_clk)
        last_r <= pins;
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the burst word store
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int DW = burst_sram_pkg::DATA_W;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [14:0] addr = 15'h0000;
    logic [DW-1:0] wdata = '0;
    logic [DW-1:0] pins, q;
    logic oe, wr_rdy, hold = 1'b0, g_n = 1'b1, we_n = 1'b1, s_hi = 1'b1, s_lo_n = 1'b0;
    logic tsp_n = 1'b1, tsc_n = 1'b1, adv_n = 1'b1;
    int errors = 0, checks = 0, cycles = 0;

    sync_burst_sram_32kx9 DUT (.ref_clk(ref_clk), .reset(reset), .word_index(addr),
        .data_pins_in(pins), .data_pins_out(q), .data_pins_oe(oe), .store_strobe_n(we_n),
        .drive_on_n(g_n), .select_active_hi(s_hi), .select_active_lo_n(s_lo_n),
        .proc_transfer_start_n(tsp_n), .ctrl_transfer_start_n(tsc_n),
        .burst_advance_n(adv_n), .array_hold(hold), .write_ready(wr_rdy));
    ctrl_side_model far (.ref_clk(ref_clk), .sram_out(q), .sram_oe(oe), .host_data(wdata),
        .host_drive(!we_n), .pins(pins));

    initial forever #4 ref_clk = ~ref_clk;

    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            $display("ERROR %0t timeout", $time);
            close_out();
        end
    end

    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ctl = {selects, proc start, ctrl start, advance, strobe}; one idle hold edge follows
    task automatic go(input logic [5:0] ctl, input logic g, input logic [14:0] a,
                      input logic [DW-1:0] d);
        @(posedge ref_clk);
        {s_hi, s_lo_n, tsp_n, tsc_n, adv_n, we_n} <= ctl;
        g_n <= g;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        {s_hi, s_lo_n, tsp_n, tsc_n, adv_n, we_n} <= 6'h2F;
        @(negedge ref_clk);
    endtask

    task automatic s_write_burst();
        go(6'h2A, 1'b1, 15'h1236, 9'h101);
        go(6'h2C, 1'b1, 15'h0000, 9'h102);
        go(6'h2C, 1'b1, 15'h0000, 9'h103);
        go(6'h2C, 1'b1, 15'h0000, 9'h104);
    endtask

    task automatic s_read_burst();
        go(6'h27, 1'b0, 15'h1236, 9'h000);
        chk(q, 9'h101);
        chk(DW'(oe), 9'h001);
        go(6'h2D, 1'b0, 15'h0000, 9'h000);
        chk(q, 9'h102);
        go(6'h2F, 1'b0, 15'h0000, 9'h000);
        chk(q, 9'h102);
        go(6'h2D, 1'b0, 15'h0000, 9'h000);
        chk(q, 9'h103);
        go(6'h2D, 1'b0, 15'h0000, 9'h000);
        chk(q, 9'h104);
        go(6'h2D, 1'b0, 15'h0000, 9'h000);
        chk(q, 9'h101);
        go(6'h2B, 1'b0, 15'h1234, 9'h000);
        chk(q, 9'h103);
        @(posedge ref_clk);
        g_n <= 1'b1;
        #2;
        chk(DW'(oe), 9'h000);
    endtask

    task automatic s_deselect();
        go(6'h3A, 1'b0, 15'h1236, 9'h1FF);
        chk(DW'(oe), 9'h000);
        go(6'h2C, 1'b0, 15'h0000, 9'h1EE);
        go(6'h07, 1'b0, 15'h1236, 9'h000);
        chk(DW'(oe), 9'h000);
        go(6'h2D, 1'b0, 15'h0000, 9'h000);
        chk(DW'(oe), 9'h000);
        go(6'h27, 1'b0, 15'h1236, 9'h000);
        chk(q, 9'h101);
        go(6'h2D, 1'b0, 15'h0000, 9'h000);
        chk(q, 9'h102);
        // Processor start with strobe low is still a read, and the pins stay off
        go(6'h26, 1'b0, 15'h1237, 9'h0AA);
        chk(q, 9'h102);
        chk(DW'(oe), 9'h000);
        go(6'h27, 1'b0, 15'h1237, 9'h000);
        chk(q, 9'h102);
    endtask

    task automatic s_fifo();
        int n;
        n = 0;
        @(posedge ref_clk);
        hold <= 1'b1;
        go(6'h2A, 1'b1, 15'h7FFC, 9'h000);
        while (wr_rdy === 1'b1 && n < 40)
        begin
            n++;
            go(6'h2C, 1'b1, 15'h0000, DW'(n));
        end
        chk(DW'(n), 9'h00F);
        @(posedge ref_clk);
        hold <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk(DW'(wr_rdy), 9'h001);
        go(6'h27, 1'b0, 15'h7FFC, 9'h000);
        chk(q, 9'h00C);
        for (int k = 1; k < 4; k++)
        begin
            go(6'h2D, 1'b0, 15'h0000, 9'h000);
            chk(q, DW'(12 + k));
        end
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        s_write_burst();
        s_read_burst();
        s_deselect();
        s_fifo();
        close_out();
    end
endmodule
`default_nettype wire
